// [verilog/mcfir_dev.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - decimation factor sets inter-tap delay registers
// R2 - up to sixteen delays per tap gap
// R3 - factor changes delay only, not output rate
// R4 - write strobe stores coefficient at tap/cell/set
// R5 - set select feeds all eight taps
// R6 - selector picks scaled sum, sum, a, b
// R7 - both path controls low pre-sums paths
// R8 - accumulate high adds, low dumps to output
// R9 - shift enable freezes delay registers
// R10 - double clocked: reverse first, forward second
// R11 - regular asymmetric disables reverse path
// R12 - symmetric eight taps resolve in one clock
// R13 - host interleaves N channels, factor N
// R14 - host uses only even symmetric lengths
// R15 - host keeps filter clock within 45 MHz
// R16 - host keeps multiplier times channels below 33
// R17 - combined cells reach sixteen or eight taps
// R18 - regular asymmetric ties controls low
// R19 - host steps set select per sample
// R20 - reset clears delays and accumulators
module mcfir_dev #(
  parameter int MAX_DECIM = mcfir_pkg::MAX_DECIM
) (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      srst,
  // link to host
  mcfir_if.dev                           link,
  // user-side status
  output var  logic [mcfir_pkg::CW_W-1:0] ctrl_word_q,
  output var  logic [1:0]                 fifo_level_q
);
  // ------------------------------------------------------------
  // local types and sizes
  // ------------------------------------------------------------
  localparam int CHAIN_LEN = (mcfir_pkg::CHAIN_TAPS - 1) * MAX_DECIM + 1;
  typedef logic signed [mcfir_pkg::DATA_W-1:0]  mcfir_smp_t;
  typedef logic signed [mcfir_pkg::COEF_W-1:0]  mcfir_coef_t;
  typedef logic signed [mcfir_pkg::SUM_W-1:0]   mcfir_sum_t;
  typedef logic signed [mcfir_pkg::OUT_W-1:0]   mcfir_out_t;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // factor 0 encodes the deepest setting of sixteen
  function automatic int decim_depth(input logic [3:0] f);
    return (f == 4'h0) ? MAX_DECIM : int'(f);  // [R2]
  endfunction

  // chain position of tap point t for the programmed depth
  function automatic int tap_index(input int t, input logic [3:0] f);
    return t * decim_depth(f);  // [R1]
  endfunction

  // output combining selector
  function automatic mcfir_out_t combine(input logic [1:0] sel,
                                         input mcfir_sum_t a,
                                         input mcfir_sum_t b);
    mcfir_out_t r;
    r = '0;
    case (sel)
      mcfir_pkg::SEL_SCALED:
        r = mcfir_out_t'(a) + mcfir_out_t'(b >>> mcfir_pkg::SCALE_SHIFT);
      mcfir_pkg::SEL_SUM: r = mcfir_out_t'(a) + mcfir_out_t'(b);  // [R17]
      mcfir_pkg::SEL_A:   r = mcfir_out_t'(a);
      mcfir_pkg::SEL_B:   r = mcfir_out_t'(b);
      default:            r = '0;
    endcase
    return r;  // [R6]
  endfunction

  // ------------------------------------------------------------
  // handshake terms
  // ------------------------------------------------------------
  logic       ready_q;      // room in the output buffer
  logic       ready_d;
  logic       step;         // one filter clock of work
  logic       shift;        // delay registers advance
  logic       push;         // a result is dumped
  logic       pop;          // host takes the head result
  logic [7:0] waddr;        // shared write address

  // every shift, accumulate and dump waits for a sample beat that found room, so a
  // stalled receiver stalls the whole filter and loses nothing
  assign step  = link.sample_valid & ready_q;
  assign shift = step & ~link.shift_enable_n;  // [R9]
  assign push  = step & ~link.accumulate_enable;  // [R8]
  assign waddr = {link.set_write_address, link.cell_select_bit,
                  link.tap_select};

  // ------------------------------------------------------------
  // control word
  // ------------------------------------------------------------
  logic [mcfir_pkg::CW_W-1:0] cw_d;  // next control word
  logic [3:0]                 dec;   // decimation factor field
  logic                       asym;  // reverse path forced off

  // next value of the control word
  always_comb begin
    cw_d = ctrl_word_q;
    if (srst) begin
      cw_d = mcfir_pkg::CW_RESET;
    end else if (link.ctrl_wr &&
                 waddr == mcfir_pkg::CTRL_ADDR_DECIM) begin
      cw_d = link.coefficient_input_bus[mcfir_pkg::CW_W-1:0];  // [R1]
    end
  end

  // register the control word
  always_ff @(posedge mclk) begin
    ctrl_word_q <= cw_d;
  end

  assign dec  = ctrl_word_q[3:0];
  assign asym = ctrl_word_q[mcfir_pkg::CW_ASYM_BIT];

  // ------------------------------------------------------------
  // delay chain shared by both cells
  // ------------------------------------------------------------
  mcfir_smp_t chain_q [CHAIN_LEN];  // decimation delay registers
  mcfir_smp_t chain_d [CHAIN_LEN];  // next contents

  // shift one place per enabled step; the factor only moves
  // the tap points, so one result still leaves per sample
  always_comb begin
    chain_d = chain_q;
    if (srst) begin
      for (int i = 0; i < CHAIN_LEN; i++) begin
        chain_d[i] = '0;  // [R20]
      end
    end else if (shift) begin
      chain_d[0] = link.sample_data;  // [R3]
      for (int i = 1; i < CHAIN_LEN; i++) begin
        chain_d[i] = chain_q[i-1];  // [R9]
      end
    end
  end

  // register the chain
  always_ff @(posedge mclk) begin
    chain_q <= chain_d;
  end

  // ------------------------------------------------------------
  // coefficient memory
  // ------------------------------------------------------------
  mcfir_coef_t coef_q [2][mcfir_pkg::SETS][mcfir_pkg::TAPS];

  // one coefficient per write strobe; contents survive reset
  always_ff @(posedge mclk) begin
    if (link.coef_wr) begin
      coef_q[link.cell_select_bit][link.set_write_address]
            [link.tap_select] <= link.coefficient_input_bus;  // [R4]
    end
  end

  // ------------------------------------------------------------
  // the two filter cells
  // ------------------------------------------------------------
  logic fwd_en;  // forward path feeds the products
  logic rev_en;  // reverse path feeds the products

  // both controls low sum the paths; the mode bit shuts the
  // reverse path for regularly clocked asymmetric work
  assign fwd_en = ~link.forward_path_control;  // [R7] [R10]
  assign rev_en = ~link.reverse_path_control & ~asym;  // [R11]

  for (genvar c = 0; c < 2; c++) begin : g_cell
    mcfir_sum_t sum;    // products of this clock
    mcfir_sum_t tot;    // accumulator plus products
    mcfir_sum_t acc_q;  // accumulator
    mcfir_sum_t acc_d;

    // cell a uses tap points 0..3 and 15..12, cell b 4..7 and
    // 11..8, so joined they form one sixteen tap chain
    always_comb begin
      logic signed [mcfir_pkg::DATA_W:0]              ps;
      logic signed [mcfir_pkg::DATA_W+mcfir_pkg::COEF_W:0] prod;
      mcfir_smp_t f;
      mcfir_smp_t r;
      ps   = '0;
      prod = '0;
      f    = '0;
      r    = '0;
      sum  = '0;
      for (int k = 0; k < mcfir_pkg::TAPS; k++) begin
        // chain_d sees the sample shifted in on this clock
        f = fwd_en ? chain_d[tap_index(4*c + k, dec)] : '0;
        r = rev_en ? chain_d[tap_index(15 - 4*c - k, dec)] : '0;
        ps = {f[mcfir_pkg::DATA_W-1], f} +
             {r[mcfir_pkg::DATA_W-1], r};  // [R7] [R12]
        prod = ps * coef_q[c][link.coefficient_set_select][k];  // [R5]
        sum = sum + mcfir_sum_t'(prod);
      end
      tot = acc_q + sum;
    end

    // accumulate while enabled, restart after each dump
    always_comb begin
      acc_d = acc_q;
      if (srst) begin
        acc_d = '0;  // [R20]
      end else if (step) begin
        acc_d = link.accumulate_enable ? tot : '0;  // [R8] [R10]
      end
    end

    // register the accumulator
    always_ff @(posedge mclk) begin
      acc_q <= acc_d;
    end
  end

  // ------------------------------------------------------------
  // two-entry output buffer
  // ------------------------------------------------------------
  mcfir_out_t buf_q [2];  // entry 0 is the head
  mcfir_out_t buf_d [2];
  logic [1:0] cnt_d;      // next fill level
  logic [1:0] rem;        // level left after a pop
  logic       valid_q;    // head holds a result
  logic       valid_d;
  mcfir_out_t newv;       // combined dump value

  assign pop  = valid_q & link.result_ready;
  assign newv = combine(link.output_combine_select, g_cell[0].tot,
                        g_cell[1].tot);  // [R6]

  // ready is registered, so it is dropped as soon as the next
  // level reaches two; a step never finds the buffer full
  always_comb begin
    buf_d   = buf_q;
    rem     = fifo_level_q;
    cnt_d   = fifo_level_q;
    valid_d = 1'b0;
    ready_d = 1'b0;
    if (srst) begin
      cnt_d = 2'h0;
    end else begin
      if (pop) begin
        buf_d[0] = buf_q[1];
        rem      = fifo_level_q - 2'h1;
      end
      if (push) begin
        buf_d[rem[0]] = newv;  // [R8]
      end
      cnt_d   = rem + {1'b0, push};
      valid_d = (cnt_d != 2'h0);
      ready_d = (cnt_d != 2'h2);
    end
  end

  // register the buffer and its flags
  always_ff @(posedge mclk) begin
    buf_q        <= buf_d;
    fifo_level_q <= cnt_d;
    valid_q      <= valid_d;
    ready_q      <= ready_d;
  end

  // ------------------------------------------------------------
  // link outputs, all straight from flip-flops
  // ------------------------------------------------------------
  assign link.sample_ready = ready_q;
  assign link.result_valid = valid_q;
  assign link.result_data  = buf_q[0];
endmodule
`default_nettype wire

// [verilog/mcfir_pkg.sv]
`default_nettype none
// --------------------------------------------------------------
// shared constants of the multichannel dual fir
// --------------------------------------------------------------
package mcfir_pkg;
  localparam int DATA_W      = 10;  // sample width
  localparam int COEF_W      = 10;  // coefficient width
  localparam int TAPS        = 4;   // taps per cell and path
  localparam int SETS        = 32;  // coefficient sets per tap
  localparam int MAX_DECIM   = 16;  // deepest inter-tap delay
  localparam int CHAIN_TAPS  = 16;  // tap points along the chain
  localparam int SUM_W       = 24;  // cell sum and accumulator
  localparam int OUT_W       = 25;  // combined output
  localparam int SCALE_SHIFT = 10;  // 2^-10 scaling of cell b
  localparam int MAX_MN      = 32;  // sets limit multiplier*chans
  localparam int CW_W        = 5;   // control word width
  localparam int CW_ASYM_BIT = 4;   // control bit: reverse path off
  localparam logic [7:0] CTRL_ADDR_DECIM = 8'h00;
  localparam logic [4:0] CW_RESET        = 5'h01;
  localparam longint MCLK_HZ     = 10_000_000;
  localparam longint FILT_MAX_HZ = 45_000_000;

  // output combining selector codes
  typedef enum logic [1:0] {
    SEL_SCALED = 2'b00,
    SEL_SUM    = 2'b01,
    SEL_A      = 2'b10,
    SEL_B      = 2'b11
  } mcfir_combine_e;

  // filtering configurations run by the host
  typedef enum logic [1:0] {
    MODE_SYM   = 2'b00,
    MODE_ASYM  = 2'b01,
    MODE_ASYM2 = 2'b10
  } mcfir_mode_e;
endpackage
`default_nettype wire

// [verilog/mcfir_if.sv]
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------
// link between host controller and filter
// --------------------------------------------------------------
interface mcfir_if;
  // multiplexed sample stream
  logic signed [mcfir_pkg::DATA_W-1:0] sample_data;
  logic                                sample_valid;
  logic                                sample_ready;
  // per-cycle controls
  logic                                forward_path_control;
  logic                                reverse_path_control;
  logic                                shift_enable_n;
  logic                                accumulate_enable;
  logic [4:0]                          coefficient_set_select;
  logic [1:0]                          output_combine_select;
  // coefficient and control word writes
  logic                                coef_wr;
  logic                                ctrl_wr;
  logic [mcfir_pkg::COEF_W-1:0]        coefficient_input_bus;
  logic [1:0]                          tap_select;
  logic                                cell_select_bit;
  logic [4:0]                          set_write_address;
  // filtered result stream
  logic signed [mcfir_pkg::OUT_W-1:0]  result_data;
  logic                                result_valid;
  logic                                result_ready;

  modport dev (
    input  sample_data, sample_valid, forward_path_control,
           reverse_path_control, shift_enable_n, accumulate_enable,
           coefficient_set_select, output_combine_select, coef_wr,
           ctrl_wr, coefficient_input_bus, tap_select,
           cell_select_bit, set_write_address, result_ready,
    output sample_ready, result_data, result_valid
  );
  modport host (
    output sample_data, sample_valid, forward_path_control,
           reverse_path_control, shift_enable_n, accumulate_enable,
           coefficient_set_select, output_combine_select, coef_wr,
           ctrl_wr, coefficient_input_bus, tap_select,
           cell_select_bit, set_write_address, result_ready,
    input  sample_ready, result_data, result_valid
  );
endinterface
`default_nettype wire

// [verilog/mcfir_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// host controller for the multichannel filter
// ------------------------------------------------------------
module mcfir_host (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          srst,
  // configuration
  input  wire logic [1:0]                    usr_mode,
  input  wire logic [4:0]                    usr_channels,
  input  wire logic [1:0]                    usr_combine,
  input  wire logic                          usr_cfg_load,
  output var  logic                          usr_cfg_err_q,
  // coefficient writes
  input  wire logic                          usr_coef_wr,
  input  wire logic [7:0]                    usr_coef_addr,
  input  wire logic [mcfir_pkg::COEF_W-1:0]  usr_coef_data,
  // interleaved samples in
  input  wire logic [mcfir_pkg::DATA_W-1:0]  usr_sample,
  input  wire logic                          usr_sample_valid,
  output var  logic                          usr_sample_ready_q,
  // filtered results out
  output var  logic [mcfir_pkg::OUT_W-1:0]   usr_result_q,
  output var  logic                          usr_result_valid_q,
  input  wire logic                          usr_result_ready,
  // link to filter
  mcfir_if.host                              link
);
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,  // waiting for a user sample
    ST_FIRST  = 2'b01,  // presenting the first filter clock
    ST_SECOND = 2'b10   // second clock of double clocking
  } mcfir_state_e;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  mcfir_state_e st_q, st_d;           // sample sequencer
  logic [1:0]   mode_q, mode_d;       // filtering configuration
  logic [4:0]   nch_q, nch_d;         // channel count
  logic [1:0]   comb_q, comb_d;       // output selector
  logic [3:0]   chan_q, chan_d;       // channel of current sample
  logic         err_d;
  logic [9:0]   sd_q, sd_d;           // sample to filter
  logic         fwc_q, fwc_d;         // forward path control
  logic         rvc_q, rvc_d;         // reverse path control
  logic         shn_q, shn_d;         // shift enable, low shifts
  logic         acc_q, acc_d;         // accumulate enable
  logic [4:0]   csel_q, csel_d;       // coefficient set select
  logic         cw_q, cw_d;           // coefficient write strobe
  logic         kw_q, kw_d;           // control word write strobe
  logic [7:0]   wa_q, wa_d;           // write address
  logic [9:0]   wd_q, wd_d;           // write data
  logic         ordy_q, ordy_d;       // ready towards the filter
  logic [mcfir_pkg::OUT_W-1:0] res_d;
  logic         resv_d;
  logic         urdy_d;
  logic         step;                 // filter took a beat
  logic         take;                 // result taken from filter
  logic         dbl;                  // double clocked mode

  assign step = (st_q != ST_IDLE) & link.sample_ready;
  assign take = link.result_valid & ordy_q;
  assign dbl  = (mode_q == mcfir_pkg::MODE_ASYM2);

  // ------------------------------------------------------------
  // next values
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q; mode_d = mode_q; nch_d = nch_q; comb_d = comb_q;
    chan_d = chan_q; err_d = usr_cfg_err_q; sd_d = sd_q;
    fwc_d = fwc_q; rvc_d = rvc_q; shn_d = shn_q; acc_d = acc_q;
    csel_d = csel_q; cw_d = 1'b0; kw_d = 1'b0;
    wa_d = wa_q; wd_d = wd_q;
    res_d = usr_result_q; resv_d = usr_result_valid_q;
    // configuration: control word carries N and the mode bit
    if (usr_cfg_load) begin
      mode_d = usr_mode; nch_d = usr_channels; comb_d = usr_combine;
      chan_d = 4'h0;
      kw_d = 1'b1;
      wa_d = mcfir_pkg::CTRL_ADDR_DECIM;
      wd_d = {5'h00, usr_mode == mcfir_pkg::MODE_ASYM,
              usr_channels[3:0]};  // [R13] [R11]
      err_d = (usr_channels == 5'h00) || (usr_channels > 5'h10) ||
              ((usr_mode == mcfir_pkg::MODE_ASYM2 ? 6'h02 : 6'h01) *
               {1'b0, usr_channels} > 6'(mcfir_pkg::MAX_MN)) ||  // [R16]
              (mcfir_pkg::MCLK_HZ > mcfir_pkg::FILT_MAX_HZ);  // [R15]
    end else if (usr_coef_wr) begin
      cw_d = 1'b1; wa_d = usr_coef_addr; wd_d = usr_coef_data;
    end
    // sample sequencing
    case (st_q)
      ST_IDLE: begin
        if (usr_sample_valid) begin
          st_d = ST_FIRST; sd_d = usr_sample; shn_d = 1'b0;
          // symmetric and regular asymmetric: all low [R7] [R18] [R14]
          acc_d = dbl;
          fwc_d = dbl;  // reverse path on the first clock [R10]
          rvc_d = 1'b0;
          csel_d = dbl ? {chan_q, 1'b0} : {1'b0, chan_q};  // [R19]
        end
      end
      ST_FIRST, ST_SECOND: begin
        if (step && dbl && st_q == ST_FIRST) begin
          st_d = ST_SECOND; shn_d = 1'b1; acc_d = 1'b0;
          fwc_d = 1'b0; rvc_d = 1'b1;  // forward on second [R10]
          csel_d = {chan_q, 1'b1};
        end else if (step) begin
          st_d = ST_IDLE; shn_d = 1'b0; acc_d = 1'b0;
          fwc_d = 1'b0; rvc_d = 1'b0;
          chan_d = ({1'b0, chan_q} + 5'h01 >= nch_q) ? 4'h0
                   : chan_q + 4'h1;  // [R13]
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // result stage
    if (usr_result_valid_q && usr_result_ready) resv_d = 1'b0;
    if (take) begin
      res_d = link.result_data; resv_d = 1'b1;
    end
    ordy_d = ~resv_d;
    urdy_d = (st_d == ST_IDLE);
    if (srst) begin
      st_d = ST_IDLE; mode_d = mcfir_pkg::MODE_SYM; nch_d = 5'h01;
      comb_d = mcfir_pkg::SEL_A; chan_d = 4'h0; err_d = 1'b0;
      fwc_d = 1'b0; rvc_d = 1'b0; shn_d = 1'b0; acc_d = 1'b0;
      csel_d = 5'h00; cw_d = 1'b0; kw_d = 1'b0; resv_d = 1'b0;
      ordy_d = 1'b0; urdy_d = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    st_q <= st_d; mode_q <= mode_d; nch_q <= nch_d; comb_q <= comb_d;
    chan_q <= chan_d; usr_cfg_err_q <= err_d; sd_q <= sd_d;
    fwc_q <= fwc_d; rvc_q <= rvc_d; shn_q <= shn_d; acc_q <= acc_d;
    csel_q <= csel_d; cw_q <= cw_d; kw_q <= kw_d;
    wa_q <= wa_d; wd_q <= wd_d; ordy_q <= ordy_d;
    usr_result_q <= res_d; usr_result_valid_q <= resv_d;
    usr_sample_ready_q <= urdy_d;
  end

  // ------------------------------------------------------------
  // link outputs
  // ------------------------------------------------------------
  assign link.sample_data            = sd_q;
  assign link.sample_valid           = (st_q != ST_IDLE);
  assign link.forward_path_control   = fwc_q;
  assign link.reverse_path_control   = rvc_q;
  assign link.shift_enable_n         = shn_q;
  assign link.accumulate_enable      = acc_q;
  assign link.coefficient_set_select = csel_q;
  assign link.output_combine_select  = comb_q;
  assign link.coef_wr                = cw_q;
  assign link.ctrl_wr                = kw_q;
  assign link.coefficient_input_bus  = wd_q;
  assign link.tap_select             = wa_q[1:0];
  assign link.cell_select_bit        = wa_q[2];
  assign link.set_write_address      = wa_q[7:3];
  assign link.result_ready           = ordy_q;
endmodule
`default_nettype wire

// [tb/mcfir_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// link checker between host and filter
// ----------------------------------------
module mcfir_props (
  // clock and reset
  input wire logic                              mclk,
  input wire logic                              srst,
  // sample and result streams
  input wire logic                              sample_valid,
  input wire logic                              sample_ready,
  input wire logic signed [mcfir_pkg::DATA_W-1:0] sample_data,
  input wire logic                              accumulate_enable,
  input wire logic                              result_valid,
  input wire logic                              result_ready,
  input wire logic signed [mcfir_pkg::OUT_W-1:0]  result_data,
  // write strobes and address
  input wire logic                              ctrl_wr,
  input wire logic                              coef_wr,
  input wire logic [4:0]                        set_write_address,
  input wire logic                              cell_select_bit,
  input wire logic [1:0]                        tap_select
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // a dump beat seen while the output buffer is empty
  sequence beat_dump_empty;
    sample_valid && sample_ready && !accumulate_enable && !result_valid;
  endsequence
  // reset checks run with reset active, so no disable there
  chk_dev_reset: assert property (disable iff (1'b0) srst |=> !sample_ready && !result_valid)
    else $error("filter outputs not cleared by reset");
  chk_host_reset: assert property (disable iff (1'b0) srst |=> !sample_valid && !ctrl_wr && !coef_wr)
    else $error("host strobes not cleared by reset");
  chk_dump_answer: assert property (beat_dump_empty |=> result_valid)
    else $error("dump beat gave no result next cycle");
  chk_result_hold: assert property (result_valid && !result_ready |=> result_valid && $stable(result_data))
    else $error("result changed before handshake");
  chk_result_drop: assert property ($fell(result_valid) |-> $past(result_ready))
    else $error("result dropped without handshake");
  chk_sample_hold: assert property (sample_valid && !sample_ready |=> sample_valid && $stable(sample_data))
    else $error("refused sample not held");
  chk_ctrl_addr: assert property (ctrl_wr |-> set_write_address == 5'h00 && !cell_select_bit && tap_select == 2'h0)
    else $error("control write off address zero");
  chk_ctrl_pulse: assert property (ctrl_wr |=> !ctrl_wr)
    else $error("control write strobe not a pulse");
endmodule
`default_nettype wire

// [tb/tb_multichannel_dual_fir_filter.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_multichannel_dual_fir_filter;
  // ----------------------------------------
  // clock, reset and user side signals
  // ----------------------------------------
  logic        mclk = 1'b0;  // 10 MHz
  logic        srst = 1'b1;  // held 20 cycles
  logic [1:0]  usr_mode, usr_combine;
  logic [4:0]  usr_channels, ctrl_word_q;
  logic        usr_cfg_load, usr_coef_wr, usr_sample_valid, usr_result_ready;
  logic        usr_cfg_err_q, usr_sample_ready_q, usr_result_valid_q;
  logic [7:0]  usr_coef_addr;
  logic [9:0]  usr_coef_data, usr_sample;
  logic [24:0] usr_result_q;
  logic [1:0]  fifo_level_q;
  int          err_count = 0, checked = 0, cycles = 0;
  // cell a taps 3,2,0,0 and cell b tap0 1 in set zero
  logic [9:0]  coef [8] = '{10'h003, 10'h002, 10'h000, 10'h000,
                            10'h001, 10'h000, 10'h000, 10'h000};
  always #50 mclk = ~mclk;
  mcfir_if link_if ();
  mcfir_dev u_mcfir_dev (.mclk(mclk), .srst(srst), .link(link_if),
    .ctrl_word_q(ctrl_word_q), .fifo_level_q(fifo_level_q));
  mcfir_host u_mcfir_host (.mclk(mclk), .srst(srst), .usr_mode(usr_mode),
    .usr_channels(usr_channels), .usr_combine(usr_combine),
    .usr_cfg_load(usr_cfg_load), .usr_cfg_err_q(usr_cfg_err_q),
    .usr_coef_wr(usr_coef_wr), .usr_coef_addr(usr_coef_addr),
    .usr_coef_data(usr_coef_data), .usr_sample(usr_sample),
    .usr_sample_valid(usr_sample_valid),
    .usr_sample_ready_q(usr_sample_ready_q), .usr_result_q(usr_result_q),
    .usr_result_valid_q(usr_result_valid_q),
    .usr_result_ready(usr_result_ready), .link(link_if));
  mcfir_props u_mcfir_props (.mclk(mclk), .srst(srst),
    .sample_valid(link_if.sample_valid), .sample_ready(link_if.sample_ready),
    .sample_data(link_if.sample_data),
    .accumulate_enable(link_if.accumulate_enable),
    .result_valid(link_if.result_valid), .result_ready(link_if.result_ready),
    .result_data(link_if.result_data), .ctrl_wr(link_if.ctrl_wr),
    .coef_wr(link_if.coef_wr), .set_write_address(link_if.set_write_address),
    .cell_select_bit(link_if.cell_select_bit),
    .tap_select(link_if.tap_select));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [24:0] exp, got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // config beat, then time for the control write to land
  task automatic cfg(input logic [1:0] m, input logic [1:0] c);
    usr_mode = m;
    usr_combine = c;
    usr_cfg_load = 1'b1;
    @(posedge mclk) #1 usr_cfg_load = 1'b0;
    repeat (3) @(posedge mclk) #1;
  endtask
  task automatic send(input logic [9:0] s);
    usr_sample = s;
    usr_sample_valid = 1'b1;
    while (usr_sample_ready_q !== 1'b1) @(posedge mclk) #1;
    @(posedge mclk) #1 usr_sample_valid = 1'b0;
    @(posedge mclk) #1;
  endtask
  task automatic get(input logic [24:0] exp);
    usr_result_ready = 1'b1;
    while (usr_result_valid_q !== 1'b1) @(posedge mclk) #1;
    chk("result", exp, usr_result_q);
    @(posedge mclk) #1 usr_result_ready = 1'b0;
    @(posedge mclk) #1;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard: whole run is well under this
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // main sequence: one channel, regular asymmetric then symmetric
  // ----------------------------------------
  initial begin
    {usr_cfg_load, usr_coef_wr, usr_sample_valid, usr_result_ready} = 4'h0;
    usr_mode = 2'h1;
    usr_combine = 2'h2;
    usr_channels = 5'h01;
    usr_coef_addr = 8'h00;
    usr_coef_data = 10'h000;
    usr_sample = 10'h000;
    repeat (20) @(posedge mclk);
    #1 srst = 1'b0;
    repeat (2) @(posedge mclk) #1;
    chk("ctrl_reset", 25'h0001, ctrl_word_q);
    chk("fifo_reset", 25'h0000, fifo_level_q);
    usr_coef_wr = 1'b1;
    for (int i = 0; i < 8; i++) begin
      usr_coef_addr = 8'(i);
      usr_coef_data = coef[i];
      @(posedge mclk) #1;
    end
    usr_coef_wr = 1'b0;
    cfg(2'h1, 2'h2);
    chk("ctrl_word", 25'h0011, ctrl_word_q);
    chk("cfg_err", 25'h0000, usr_cfg_err_q);
    // results stall at the user side while three samples go in
    send(10'h005);
    send(10'h007);
    send(10'h3fc);
    repeat (4) @(posedge mclk) #1;
    chk("fifo_full", 25'h0002, fifo_level_q);
    get(25'h000f);
    get(25'h001f);
    get(25'h0002);
    send(10'h001);
    get(25'h1ff_fffb);
    cfg(2'h0, 2'h1);
    chk("ctrl_sym", 25'h0001, ctrl_word_q);
    send(10'h000);
    get(25'h0007);
    end_of_test();
  end
endmodule
`default_nettype wire
